/* File: design/srs_pkg.sv */
/*
  Shared constants for the station reset and selection block: register
  offsets, field positions, reset values and the reset stretch count.
  Assumes a 32-bit APB register bus and a single board clock.
*/
package srs_pkg;

  // Board clock rate in MHz.
  localparam int unsigned CLK_MHZ        = 125;

  // Register byte offsets.
  localparam logic [7:0]  ADDR_PORT_OFS  = 8'h00;
  localparam logic [7:0]  SOFT_RST_OFS   = 8'h04;
  localparam logic [7:0]  STATUS_OFS     = 8'h08;
  localparam logic [7:0]  CONFIG_OFS     = 8'h0c;

  // Selection byte fields.
  localparam int unsigned STATION_LSB    = 0;
  localparam int unsigned STATION_W      = 5;
  localparam int unsigned FIRST_SEL_BIT  = 5;
  localparam int unsigned SECOND_SEL_BIT = 6;
  localparam int unsigned BROADCAST_BIT  = 7;
  localparam logic [7:0]  ADDR_PORT_RST  = 8'h00;

  // Station address that doubles as the reset address.
  localparam logic [4:0]  RESET_STATION  = 5'h1f;

  // Software reset command strobe bit.
  localparam int unsigned SOFT_GO_BIT    = 0;

  // Status register fields.
  localparam int unsigned ST_RESET_BIT   = 0;
  localparam int unsigned ST_SELECT_BIT  = 1;
  localparam int unsigned ST_BUTTON_BIT  = 2;
  localparam int unsigned ST_REQUEST_BIT = 3;
  localparam int unsigned ST_JUMPER_LSB  = 4;

  // Config register fields.
  localparam int unsigned CF_STATION_LSB = 0;
  localparam int unsigned CF_SINGLE_BIT  = 5;

  // Cycles the station reset is held after the request goes away.
  localparam logic [1:0]  STRETCH_CYCLES = 2'd2;

  // Reset source jumper positions.
  typedef enum logic [1:0] {
    SRS_SRC_NONE,
    SRS_SRC_PIN,
    SRS_SRC_ADDR31
  } srs_src_t;

endpackage : srs_pkg

/* File: design/srs_top.sv */
/*
  Station reset and selection glue: combines the reset sources under the
  reset source jumper, stretches the station reset, decodes the address
  port into controller selects, issues the software reset command and
  routes the shared interrupt lines to the host.
  Assumes all pins are asynchronous to pclk and an APB master on pclk.
*/

module srs_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_pushbutton,
  input  wire logic        reset_request_pin,
  input  wire logic [1:0]  reset_source_jumper,
  input  wire logic [4:0]  address_jumper_strip,
  input  wire logic        single_station_jumper,
  input  wire logic        low_interrupt_line,
  input  wire logic        high_interrupt_line,
  output logic             station_reset,
  output logic             first_controller_select,
  output logic             second_controller_select,
  output logic             broadcast_select,
  output logic             response_enable,
  output logic             response_from_second,
  output logic             first_controller_soft_reset,
  output logic             second_controller_soft_reset,
  output logic             decoder_soft_reset,
  output logic             low_irq_event,
  output logic             high_irq_event,
  output logic             host_low_irq,
  output logic             host_high_irq
);

  localparam int unsigned SYNC_W = 12;

  // Pushbutton, request pin, jumper pair, strip, single jumper, two irqs.
  logic [SYNC_W-1:0]  pins_raw;
  logic [SYNC_W-1:0]  sync1_r;
  logic [SYNC_W-1:0]  sync2_r;
  logic               button_s;
  logic               request_s;
  logic [1:0]         jumper_s;
  logic [4:0]         strip_s;
  logic               single_s;
  logic               irq_low_s;
  logic               irq_high_s;
  logic               irq_low_d_r;
  logic               irq_high_d_r;

  logic [7:0]         addr_port_r;
  logic               hw_request;
  logic               station_match;
  logic               selected;
  logic               first_exec;
  logic               second_exec;
  logic [1:0]         stretch_r;
  srs_pkg::srs_src_t  src;

  typedef enum logic [1:0] {
    SRS_RUN,
    SRS_HOLD,
    SRS_STRETCH
  } srs_state_t;
  srs_state_t         state_r;

  logic               access;
  logic               wr_fire;
  logic               soft_go;

  logic [31:0]        prdata_r;
  logic               pready_r;
  logic               pslverr_r;
  logic               station_reset_r;
  logic               first_sel_r;
  logic               second_sel_r;
  logic               broadcast_r;
  logic               resp_en_r;
  logic               resp_second_r;
  logic               first_soft_r;
  logic               second_soft_r;
  logic               decoder_soft_r;
  logic               low_evt_r;
  logic               high_evt_r;
  logic               host_low_r;
  logic               host_high_r;

  // True when the offset names one of the four registers.
  function automatic logic srs_mapped(input logic [7:0] ofs);
    srs_mapped = (ofs == srs_pkg::ADDR_PORT_OFS) || (ofs == srs_pkg::SOFT_RST_OFS) ||
                 (ofs == srs_pkg::STATUS_OFS) || (ofs == srs_pkg::CONFIG_OFS);
  endfunction : srs_mapped

  // Both jumper positions fitted at once is treated as no source, the safe side.
  function automatic srs_pkg::srs_src_t srs_src_decode(input logic [1:0] jp);
    case (jp)
      2'b01:   srs_src_decode = srs_pkg::SRS_SRC_PIN;
      2'b10:   srs_src_decode = srs_pkg::SRS_SRC_ADDR31;
      default: srs_src_decode = srs_pkg::SRS_SRC_NONE;
    endcase
  endfunction : srs_src_decode

  assign pins_raw = {high_interrupt_line, low_interrupt_line, single_station_jumper,
                     address_jumper_strip, reset_source_jumper, reset_request_pin,
                     reset_pushbutton};

  // Two flops per pin; only the second stage is read by any logic.
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end
        else
        begin
          sync1_r[gi] <= pins_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  assign button_s   = sync2_r[0];
  assign request_s  = sync2_r[1];
  assign jumper_s   = sync2_r[3:2];
  assign strip_s    = sync2_r[8:4];
  assign single_s   = sync2_r[9];
  assign irq_low_s  = sync2_r[10];
  assign irq_high_s = sync2_r[11];

  // Request sources gated by the jumper; the pushbutton always resets.
  always_comb
  begin
    src        = srs_src_decode(jumper_s);
    hw_request = button_s;
    case (src)
      srs_pkg::SRS_SRC_PIN:    hw_request = button_s | request_s;
      srs_pkg::SRS_SRC_ADDR31: hw_request = button_s |
        (addr_port_r[srs_pkg::STATION_LSB +: srs_pkg::STATION_W] == srs_pkg::RESET_STATION);
      default:                 hw_request = button_s;
    endcase
  end

  // Reset sequencer: hold while requested, then stretch a fixed count.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r   <= SRS_HOLD;
      stretch_r <= srs_pkg::STRETCH_CYCLES;
    end
    else
    begin
      case (state_r)
        SRS_RUN:
        begin
          if (hw_request)
            state_r <= SRS_HOLD;
        end
        SRS_HOLD:
        begin
          stretch_r <= srs_pkg::STRETCH_CYCLES;
          if (!hw_request)
            state_r <= SRS_STRETCH;
        end
        SRS_STRETCH:
        begin
          if (hw_request)
            state_r <= SRS_HOLD;
          else if (stretch_r == 2'd1)
            state_r <= SRS_RUN;
          else
            stretch_r <= stretch_r - 2'd1;
        end
        default: state_r <= SRS_HOLD;
      endcase
    end
  end

  // Reset is visible the cycle after the request is seen and through the stretch.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      station_reset_r <= 1'b1;
    else
      station_reset_r <= hw_request || (state_r == SRS_HOLD) ||
                         (state_r == SRS_STRETCH && stretch_r != 2'd1);
  end

  // APB slave: pready rises one cycle after setup, so every access takes two cycles.
  assign access  = psel && penable && pready_r;
  assign wr_fire = access && pwrite && srs_mapped(paddr);
  assign soft_go = wr_fire && (paddr == srs_pkg::SOFT_RST_OFS) && pwdata[srs_pkg::SOFT_GO_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && !srs_mapped(paddr);
      prdata_r  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          srs_pkg::ADDR_PORT_OFS: prdata_r[7:0] <= addr_port_r;
          srs_pkg::STATUS_OFS:
          begin
            prdata_r[srs_pkg::ST_RESET_BIT]        <= station_reset_r;
            prdata_r[srs_pkg::ST_SELECT_BIT]       <= selected;
            prdata_r[srs_pkg::ST_BUTTON_BIT]       <= button_s;
            prdata_r[srs_pkg::ST_REQUEST_BIT]      <= request_s;
            prdata_r[srs_pkg::ST_JUMPER_LSB +: 2]  <= jumper_s;
          end
          srs_pkg::CONFIG_OFS:
          begin
            prdata_r[srs_pkg::CF_STATION_LSB +: 5] <= strip_s;
            prdata_r[srs_pkg::CF_SINGLE_BIT]       <= single_s;
          end
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Address port: cleared by any station reset and by the soft command, as decoders restart at 0.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addr_port_r <= srs_pkg::ADDR_PORT_RST;
    else if (station_reset_r || soft_go)
      addr_port_r <= srs_pkg::ADDR_PORT_RST;
    else if (wr_fire && paddr == srs_pkg::ADDR_PORT_OFS)
      addr_port_r <= pwdata[7:0];
  end

  // Station match: the single-station jumper bypasses the address compare.
  assign station_match = single_s ||
    (addr_port_r[srs_pkg::STATION_LSB +: srs_pkg::STATION_W] == strip_s);
  assign selected      = station_match && !station_reset_r;
  // Broadcast makes every station execute, but only the selected one answers.
  assign first_exec    = addr_port_r[srs_pkg::FIRST_SEL_BIT] &&
    (selected || (addr_port_r[srs_pkg::BROADCAST_BIT] && !station_reset_r));
  assign second_exec   = addr_port_r[srs_pkg::SECOND_SEL_BIT] &&
    (selected || (addr_port_r[srs_pkg::BROADCAST_BIT] && !station_reset_r));

  // Registered selects; with a zero port neither controller is enabled.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_sel_r   <= 1'b0;
      second_sel_r  <= 1'b0;
      broadcast_r   <= 1'b0;
      resp_en_r     <= 1'b0;
      resp_second_r <= 1'b0;
    end
    else
    begin
      first_sel_r   <= first_exec;
      second_sel_r  <= second_exec;
      broadcast_r   <= addr_port_r[srs_pkg::BROADCAST_BIT] && !station_reset_r;
      resp_en_r     <= selected && (addr_port_r[srs_pkg::FIRST_SEL_BIT] || addr_port_r[srs_pkg::SECOND_SEL_BIT]);
      resp_second_r <= addr_port_r[srs_pkg::SECOND_SEL_BIT] && !addr_port_r[srs_pkg::FIRST_SEL_BIT];
    end
  end

  // Soft reset reaches only executing controllers; the decoder is reset on every command.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_soft_r   <= 1'b0;
      second_soft_r  <= 1'b0;
      decoder_soft_r <= 1'b0;
    end
    else
    begin
      first_soft_r   <= soft_go && first_exec;
      second_soft_r  <= soft_go && second_exec;
      decoder_soft_r <= soft_go;
    end
  end

  // Rising edges on the shared lines only; a held level raises one event.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_low_d_r  <= 1'b0;
      irq_high_d_r <= 1'b0;
      low_evt_r    <= 1'b0;
      high_evt_r   <= 1'b0;
      host_low_r   <= 1'b0;
      host_high_r  <= 1'b0;
    end
    else
    begin
      irq_low_d_r  <= irq_low_s;
      irq_high_d_r <= irq_high_s;
      low_evt_r    <= irq_low_s && !irq_low_d_r;
      high_evt_r   <= irq_high_s && !irq_high_d_r;
      host_low_r   <= irq_low_s && !irq_low_d_r && selected;
      host_high_r  <= irq_high_s && !irq_high_d_r && selected;
    end
  end

  assign prdata                       = prdata_r;
  assign pready                       = pready_r;
  assign pslverr                      = pslverr_r;
  assign station_reset                = station_reset_r;
  assign first_controller_select      = first_sel_r;
  assign second_controller_select     = second_sel_r;
  assign broadcast_select             = broadcast_r;
  assign response_enable              = resp_en_r;
  assign response_from_second         = resp_second_r;
  assign first_controller_soft_reset  = first_soft_r;
  assign second_controller_soft_reset = second_soft_r;
  assign decoder_soft_reset           = decoder_soft_r;
  assign low_irq_event                = low_evt_r;
  assign high_irq_event               = high_evt_r;
  assign host_low_irq                 = host_low_r;
  assign host_high_irq                = host_high_r;

endmodule : srs_top

/* File: test/srs_checker_sva.sv */
/*
  Concurrent checks on the ports of srs_top.
  Assumes one clock domain, pclk, with presetn as its asynchronous active-low reset.
*/
module srs_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        reset_pushbutton,
  input wire logic        reset_request_pin,
  input wire logic [1:0]  reset_source_jumper,
  input wire logic        low_interrupt_line,
  input wire logic        station_reset,
  input wire logic        first_controller_select,
  input wire logic        broadcast_select,
  input wire logic        first_controller_soft_reset,
  input wire logic        decoder_soft_reset,
  input wire logic        low_irq_event,
  input wire logic        host_low_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A committed write of the reset address; the jumper decides what it may do.
  logic wr31;
  assign wr31 = psel && penable && pready && pwrite && paddr == srs_pkg::ADDR_PORT_OFS
                && pwdata[4:0] == srs_pkg::RESET_STATION;

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_button_released;
    reset_pushbutton [*4] ##1 !reset_pushbutton;
  endsequence
  property p_ready;
    s_setup |=> pready ##1 !pready;
  endproperty
  property p_button;
    s_button_released |-> station_reset [*3];
  endproperty
  property p_pin;
    (reset_source_jumper == 2'b01 && reset_request_pin) [*5] |-> station_reset;
  endproperty
  property p_addr31;
    wr31 && reset_source_jumper == 2'b10 && !station_reset |=> ##1 station_reset;
  endproperty
  property p_none;
    wr31 && reset_source_jumper == 2'b00 && !station_reset && !reset_pushbutton |=> ##1 !station_reset;
  endproperty
  property p_idle;
    station_reset [*4] |-> !first_controller_select && !broadcast_select;
  endproperty
  property p_soft_sel;
    first_controller_soft_reset |-> decoder_soft_reset && $past(first_controller_select);
  endproperty
  property p_soft_pulse;
    decoder_soft_reset |=> !decoder_soft_reset;
  endproperty
  property p_irq;
    low_irq_event |-> $past(low_interrupt_line, 2) ##1 !low_irq_event;
  endproperty
  property p_host;
    host_low_irq |-> low_irq_event;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
  a_button: assert property (p_button)
    else $error("pushbutton reset missing or not stretched");
  a_pin: assert property (p_pin) else $error("request pin did not reset");
  a_addr31: assert property (p_addr31) else $error("address 31 did not reset");
  a_none: assert property (p_none) else $error("reset with no jumper fitted");
  a_idle: assert property (p_idle) else $error("select active during reset");
  a_soft_sel: assert property (p_soft_sel) else $error("soft reset of idle controller");
  a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset not one cycle");
  a_irq: assert property (p_irq) else $error("interrupt event without edge");
  a_host: assert property (p_host) else $error("host interrupt without event");
endmodule : srs_checker

/* File: test/srs_host_model.sv */
/*
  Far-side model: the host and the operator acting on the station pins.
  Assumes a free-running pclk from the bench; lines change just after a rising edge.
*/
module srs_host_model (
  input  wire logic pclk,
  output logic      reset_pushbutton,
  output logic      reset_request_pin,
  output logic      low_interrupt_line,
  output logic      high_interrupt_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lines_r = 4'h0;

  // Idle low between pulses, as the board's pull-downs would leave them.
  assign {high_interrupt_line, low_interrupt_line, reset_request_pin, reset_pushbutton} = lines_r;

  // High for n cycles, then low as long, so each edge stands clear of the next one.
  task automatic hold(input int which, input int n);
    @(posedge pclk);
    lines_r[which] <= 1'b1;
    repeat (n) @(posedge pclk);
    lines_r[which] <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : hold
endmodule : srs_host_model

/* File: test/srs_top_bench.sv */
/*
  Bench top for srs_top: APB driver, random selection traffic, reset, soft reset and interrupt tests.
  Assumes srs_pkg, srs_top, the host model and the checker are compiled before it.
*/
module srs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, err, f, s, b, m, single_station_jumper;
  logic        pready, pslverr, reset_pushbutton, reset_request_pin, low_interrupt_line;
  logic        high_interrupt_line, station_reset, first_controller_select, second_controller_select;
  logic        broadcast_select, response_enable, response_from_second, first_controller_soft_reset;
  logic        second_controller_soft_reset, decoder_soft_reset, low_irq_event, high_irq_event;
  logic        host_low_irq, host_high_irq;
  logic [1:0]  reset_source_jumper;
  logic [4:0]  address_jumper_strip, st;
  logic [7:0]  ev;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          num_errors, checks, seed, i, k;
  int          pulses [8];

  srs_top srs_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .reset_pushbutton, .reset_request_pin, .reset_source_jumper, .address_jumper_strip,
    .single_station_jumper, .low_interrupt_line, .high_interrupt_line, .station_reset,
    .first_controller_select, .second_controller_select, .broadcast_select, .response_enable,
    .response_from_second, .first_controller_soft_reset, .second_controller_soft_reset,
    .decoder_soft_reset, .low_irq_event, .high_irq_event, .host_low_irq, .host_high_irq);
  srs_host_model srs_host_model_i (.pclk, .reset_pushbutton, .reset_request_pin,
    .low_interrupt_line, .high_interrupt_line);

  // Board clock, 8 ns period.
  always #4 pclk = ~pclk;

  // One-cycle outputs are tallied at every edge, so none slips between two polls.
  assign ev = {host_high_irq, high_irq_event, host_low_irq, low_irq_event, station_reset,
               second_controller_soft_reset, first_controller_soft_reset, decoder_soft_reset};
  always @(posedge pclk)
    for (int j = 0; j < 8; j++)
      pulses[j] <= pulses[j] + 32'(ev[j] === 1'b1);

  // Clears the tallies after the edge's own updates have landed.
  task automatic clr;
    #1;
    pulses = '{default: 0};
  endtask : clr

  // Selection byte as the host forms it.
  function automatic logic [31:0] sb(input logic [4:0] n, input logic f1, input logic s1, input logic b1);
    return 32'(n) + (f1 ? 32'd32 : 32'd0) + (s1 ? 32'd64 : 32'd0) + (b1 ? 32'd128 : 32'd0);
  endfunction : sb

  function automatic logic [31:0] sel3();
    return 32'({first_controller_select, second_controller_select, broadcast_select});
  endfunction : sel3

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // One APB transfer; the request stays put until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      num_errors++;
      conclude();
    end
  endtask : apb

  // Bounded wait for the station reset to end; a hang counts as a mismatch.
  task automatic wait_clear;
    for (k = 0; k < 60 && station_reset !== 1'b0; k++)
      @(posedge pclk);
    if (station_reset !== 1'b0)
    begin
      num_errors++;
      conclude();
    end
  endtask : wait_clear

  // Main sequence; each loop is a table of like cases.
  initial
  begin
    seed = 32'h17616c91;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reset_source_jumper = 2'b00;
    single_station_jumper = 1'b0;
    address_jumper_strip = {1'b0, 4'($random(seed))};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_clear();
    apb(1'b0, srs_pkg::ADDR_PORT_OFS, 32'h0);
    chk("port", 32'h0, rd);
    chk("selects", 32'h0, sel3());
    apb(1'b0, srs_pkg::CONFIG_OFS, 32'h0);
    chk("config", 32'({1'b0, address_jumper_strip}), rd);
    apb(1'b0, srs_pkg::STATUS_OFS, 32'h0);
    chk("status", 32'({address_jumper_strip == 5'h00, 1'b0}), rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    $display("test registers done");
    for (i = 0; i < 16; i++)
    begin
      st = (i % 2 == 1) ? address_jumper_strip : 5'($random(seed));
      if (i == 2)
        st = 5'h1f;
      {f, s, b, single_station_jumper} <= 4'($random(seed));
      repeat (3) @(posedge pclk);
      m = single_station_jumper | (st == address_jumper_strip);
      apb(1'b1, srs_pkg::ADDR_PORT_OFS, sb(st, f, s, b));
      @(posedge pclk);
      #1;
      chk("selects", 32'({f & (m | b), s & (m | b), b}), sel3());
      if (m)
        chk("response", 32'({f | s, s & ~f}), 32'({response_enable, response_from_second}));
      chk("no reset", 32'h0, 32'(station_reset));
      apb(1'b0, srs_pkg::ADDR_PORT_OFS, 32'h0);
      chk("port", sb(st, f, s, b), rd);
    end
    single_station_jumper <= 1'b0;
    $display("test selection done");
    for (i = 0; i < 4; i++)
    begin
      reset_source_jumper <= (i == 2) ? 2'b01 : (i == 3) ? 2'b11 : 2'b00;
      apb(1'b1, srs_pkg::ADDR_PORT_OFS, sb(address_jumper_strip, 1'b1, 1'b0, 1'b0));
      clr();
      srs_host_model_i.hold((i == 0) ? 0 : 1, 6);
      wait_clear();
      chk("reset cycles", (i % 2 == 1) ? 32'h0 : 32'h1, 32'(pulses[3] >= 8));
      apb(1'b0, srs_pkg::ADDR_PORT_OFS, 32'h0);
      chk("port", (i % 2 == 1) ? sb(address_jumper_strip, 1'b1, 1'b0, 1'b0) : 32'h0, rd);
    end
    $display("test hardware resets done");
    reset_source_jumper <= 2'b10;
    repeat (3) @(posedge pclk);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, srs_pkg::ADDR_PORT_OFS, sb(5'h1e + 5'(i), 1'b1, 1'b0, 1'b0));
      @(posedge pclk);
      #1;
      chk("address reset", 32'(i), 32'(station_reset));
    end
    wait_clear();
    reset_source_jumper <= 2'b00;
    $display("test address reset done");
    for (i = 0; i < 3; i++)
    begin
      st = (i == 1) ? address_jumper_strip : address_jumper_strip ^ 5'h01;
      apb(1'b1, srs_pkg::ADDR_PORT_OFS, sb(st, i < 2, i != 1, i == 0));
      clr();
      apb(1'b1, srs_pkg::SOFT_RST_OFS, 32'h1);
      repeat (3) @(posedge pclk);
      chk("soft", {20'h0, 4'h1, 4'(i < 2), 4'(i == 0)}, 32'({4'(pulses[0]), 4'(pulses[1]), 4'(pulses[2])}));
    end
    $display("test soft reset done");
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, srs_pkg::ADDR_PORT_OFS, sb(address_jumper_strip ^ 5'(i), 1'b1, 1'b0, 1'b0));
      clr();
      srs_host_model_i.hold(2, 4);
      chk("irq", 32'({4'h1, 4'(i == 0)}), 32'({4'(pulses[4]), 4'(pulses[5])}));
      srs_host_model_i.hold(3, 4);
      chk("irq high", 32'({4'h1, 4'(i == 0)}), 32'({4'(pulses[6]), 4'(pulses[7])}));
    end
    $display("test interrupts done");
    conclude();
  end
endmodule : srs_top_bench

bind srs_top srs_checker srs_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .reset_pushbutton, .reset_request_pin, .reset_source_jumper, .low_interrupt_line,
  .station_reset, .first_controller_select, .broadcast_select, .first_controller_soft_reset,
  .decoder_soft_reset, .low_irq_event, .host_low_irq);
